// >>> hw/dtu_pkg.sv
// Package for the DAQ trigger and update timing block.
// Assumes a single 40 MHz clock and an AHB-Lite register bus with 32-bit data.
package dtu_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_INTERVAL = 8'h04;
	localparam logic [7:0] OFS_COUNT    = 8'h08;
	localparam logic [7:0] OFS_DAC0     = 8'h0c;
	localparam logic [7:0] OFS_DAC1     = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

	// Control field positions
	localparam int CTRL_START     = 0;
	localparam int CTRL_EXT_CONV  = 1;
	localparam int CTRL_HW_TRIG   = 2;
	localparam int CTRL_EARLY     = 3;
	localparam int CTRL_CONTROLED = 4;
	localparam int CTRL_DEFERRED  = 5;
	localparam int CTRL_UPD_IRQ   = 6;
	localparam int CTRL_GP_START  = 7;
	localparam int CTRL_W         = 8;

	// Interrupt status bits
	localparam int IRQ_UPDATE = 0;
	localparam int IRQ_DONE   = 1;
	localparam int IRQ_W      = 2;

	localparam int DAC_W = 12;
	localparam int CNT_W = 16;

	localparam logic [CTRL_W-1:0] CTRL_RST     = 8'h00;
	localparam logic [CNT_W-1:0]  INTERVAL_RST = 16'h0028;
	localparam logic [CNT_W-1:0]  COUNT_RST    = 16'h0003;
	localparam logic [CNT_W-1:0]  CNT_MAX      = 16'hffff;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_WAIT  = 4'b0010,
		ST_ARMED = 4'b0100,
		ST_RUN   = 4'b1000
	} dtu_state_e;

	// Synchronised input samples, two stages each plus a previous value
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] prev;
	} dtu_sync_s;

	typedef struct packed {
		logic              hsel;
		logic              hwrite;
		logic [7:0]        haddr;
	} dtu_aphase_s;

	typedef struct packed {
		dtu_sync_s          sync;
		dtu_aphase_s        ap;
		logic               ap_valid;
		logic [CTRL_W-1:0]  ctrl;
		logic [CNT_W-1:0]   interval;
		logic [CNT_W-1:0]   count;
		logic [DAC_W-1:0]   dac0_hold;
		logic [DAC_W-1:0]   dac1_hold;
		logic               dac_pending;
		logic [DAC_W-1:0]   dac0_out;
		logic [DAC_W-1:0]   dac1_out;
		logic [IRQ_W-1:0]   irq_stat;
		logic [IRQ_W-1:0]   irq_mask;
		logic               irq;
		dtu_state_e         state;
		logic               trig_locked;
		logic [CNT_W-1:0]   int_cnt;
		logic [CNT_W-1:0]   smp_cnt;
		logic               smp_loaded;
		logic               smp_gate;
		logic               conv_en;
		logic               conv_pulse;
		logic               dac_strobe;
		logic [31:0]        hrdata;
	} dtu_state_s;

	// Register decode used by both read and write paths
	function automatic logic [3:0] dtu_reg_index(input logic [7:0] addr);
		return addr[5:2];
	endfunction

endpackage

// >>> hw/dtu_core.sv
// DAQ trigger and update timing: conversion start, trigger modes, DAC update.
// Assumes external inputs synchronous to hclk and one AHB-Lite master.
//
// Notes on behaviour
// - Interval counter paces timed conversions; sample counter counts them; interval counter private, sample counter low 12 bits read in STATUS.
// - With external timing, each falling edge of ext_convert_n starts one conversion.
// - Software picks hardware trigger mode or early capture mode for the trigger.
// - Hardware trigger mode holds the interval counter off until trigger rises.
// - External conversions enable from first convert rising edge after the trigger.
// - Trigger while convert high: second falling edge; while low: next one.
// - After triggering, further trigger edges are ignored until a new sequence.
// - Controlled acquisition stops conversions when the sample count expires.
// - Sample counter loads late, so two extra conversions occur beyond the count.
// - The trigger also starts free-run acquisition with no sample limit.
// - Early capture converts at once; sample counter waits for the trigger edge.
// - Early capture runs the count after trigger then stops; needs controlled mode.
// - Only one trigger mode is active at a time.
// - General-purpose counter 1 output may gate interval-timed conversions; the interval counter runs regardless.
// - Immediate update mode moves the 12-bit DAC value out on write.
// - Deferred mode transfers DAC values while ext_dac_load_n is low.
// - Update interrupt fires on each rising edge of ext_dac_load_n when enabled.
// - host_irq stays high until irq_clear, a status clear or a set mask bit.
`timescale 1ns/1ps

module dtu_core (
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    hsel,
	input  wire logic [7:0]              haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	input  wire logic                    ext_convert_n,
	input  wire logic                    ext_trigger_in,
	input  wire logic                    ext_dac_load_n,
	input  wire logic                    gp_counter1_out,
	input  wire logic                    irq_clear,
	output logic                         adc_convert,
	output logic                         dac_write_strobe,
	output logic      [dtu_pkg::DAC_W-1:0] dac0_value,
	output logic      [dtu_pkg::DAC_W-1:0] dac1_value,
	output logic                         host_irq
);
	import dtu_pkg::*;

	dtu_state_s r, n;

	logic conv_fall, conv_rise, trig_rise, upd_rise, upd_low, gp_level;
	logic wr_go, rd_go;
	logic [3:0] widx;
	logic [IRQ_W-1:0] ev;
	logic tick, smp_expire;

	////////////////////////////////////////////////////////////////////////////
	// Edge detection on second sync stage only; the first stage is metastable-prone
	assign conv_fall = r.sync.prev[0] & ~r.sync.s2[0];
	assign conv_rise = ~r.sync.prev[0] & r.sync.s2[0];
	assign trig_rise = ~r.sync.prev[1] & r.sync.s2[1];
	assign upd_rise  = ~r.sync.prev[2] & r.sync.s2[2];
	assign upd_low   = ~r.sync.s2[2];
	assign gp_level  = gp_counter1_out;

	assign wr_go = r.ap_valid & r.ap.hwrite;
	assign rd_go = hsel & hready & htrans[1] & ~hwrite;
	assign widx  = dtu_reg_index(r.ap.haddr);

	always_comb begin
		n = r;
		n.sync.s1   = {ext_dac_load_n, ext_trigger_in, ext_convert_n};
		n.sync.s2   = r.sync.s1;
		n.sync.prev = r.sync.s2;
		n.conv_pulse = 1'b0;
		n.dac_strobe = 1'b0;
		ev   = '0;
		tick = 1'b0;
		smp_expire = 1'b0;

		// Bus address phase capture
		n.ap_valid = hsel & hready & htrans[1] & hwrite;
		n.ap.hsel   = hsel;
		n.ap.hwrite = hwrite;
		n.ap.haddr  = haddr;

		////////////////////////////////////////////////////////////////////////
		// Register writes
		if (wr_go) begin
			case (widx)
				OFS_CTRL[5:2]: begin
					n.ctrl = hwdata[CTRL_W-1:0];
					// Early capture wins; both modes share the trigger input
					if (hwdata[CTRL_EARLY]) begin
						n.ctrl[CTRL_HW_TRIG]   = 1'b0;
						n.ctrl[CTRL_CONTROLED] = 1'b1;
					end
				end
				OFS_INTERVAL[5:2]: n.interval = hwdata[CNT_W-1:0];
				OFS_COUNT[5:2]:    n.count    = hwdata[CNT_W-1:0];
				OFS_DAC0[5:2]: begin
					n.dac0_hold   = hwdata[DAC_W-1:0];
					n.dac_pending = 1'b1;
					n.dac_strobe  = 1'b1;
				end
				OFS_DAC1[5:2]: begin
					n.dac1_hold   = hwdata[DAC_W-1:0];
					n.dac_pending = 1'b1;
					n.dac_strobe  = 1'b1;
				end
				OFS_IRQ_MASK[5:2]: n.irq_mask = hwdata[IRQ_W-1:0];
				default: ;
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// Acquisition sequencer
		unique case (r.state)
			ST_IDLE: begin
				n.conv_en    = 1'b0;
				n.smp_gate   = 1'b0;
				n.smp_loaded = 1'b0;
				n.trig_locked = 1'b0;
				if (r.ctrl[CTRL_START]) begin
					n.int_cnt = r.interval;
					if (r.ctrl[CTRL_HW_TRIG]) begin
						n.state = ST_WAIT;
					end else begin
						n.state   = ST_RUN;
						n.conv_en = 1'b1;
						// Sample counter waits for the trigger in early capture
						n.smp_gate = ~r.ctrl[CTRL_EARLY];
					end
				end
			end
			ST_WAIT: begin
				if (trig_rise) begin
					n.trig_locked = 1'b1;
					n.smp_gate    = 1'b1;
					n.state       = r.ctrl[CTRL_EXT_CONV] ? ST_ARMED : ST_RUN;
					n.conv_en     = ~r.ctrl[CTRL_EXT_CONV];
				end
			end
			ST_ARMED: begin
				// Trigger while convert high means a fall precedes this rise
				if (conv_rise) begin
					n.conv_en = 1'b1;
					n.state   = ST_RUN;
				end
			end
			ST_RUN: begin
				if (r.ctrl[CTRL_EARLY] && !r.trig_locked && trig_rise) begin
					n.smp_gate    = 1'b1;
					n.trig_locked = 1'b1;
				end
			end
			default: n.state = ST_IDLE;
		endcase

		// Conversion sources
		if (r.state == ST_RUN && r.conv_en) begin
			if (r.ctrl[CTRL_EXT_CONV]) begin
				tick = conv_fall;
			end else if (r.ctrl[CTRL_GP_START]) begin
				tick = gp_level & (r.int_cnt == '0);
			end else begin
				tick = (r.int_cnt == '0);
			end
			if (!r.ctrl[CTRL_EXT_CONV]) begin
				n.int_cnt = (r.int_cnt == '0) ? r.interval : r.int_cnt - 16'h0001;
			end
		end

		if (tick) begin
			n.conv_pulse = 1'b1;
			// Count loads on the first tick after gating, giving two extra pulses
			if (r.smp_gate && r.ctrl[CTRL_CONTROLED]) begin
				if (!r.smp_loaded) begin
					n.smp_loaded = 1'b1;
					n.smp_cnt    = r.count;
				end else if (r.smp_cnt != '0) begin
					n.smp_cnt = r.smp_cnt - 16'h0001;
				end else begin
					// Last pulse issues while the count already reads zero
					smp_expire = 1'b1;
				end
			end
		end

		if (r.state == ST_RUN && r.ctrl[CTRL_CONTROLED] && smp_expire) begin
			n.conv_en = 1'b0;
			n.state   = ST_IDLE;
			n.ctrl[CTRL_START] = 1'b0;
			ev[IRQ_DONE] = 1'b1;
		end
		if (wr_go && widx == OFS_CTRL[5:2] && !hwdata[CTRL_START]) begin
			n.state = ST_IDLE;
		end

		////////////////////////////////////////////////////////////////////////
		// DAC update
		if (!n.ctrl[CTRL_DEFERRED] || upd_low) begin
			if (n.dac_pending) begin
				n.dac0_out    = n.dac0_hold;
				n.dac1_out    = n.dac1_hold;
				n.dac_pending = 1'b0;
			end
		end
		ev[IRQ_UPDATE] = upd_rise & r.ctrl[CTRL_UPD_IRQ];

		// Sticky status: set wins over a write-one clear or irq_clear
		if (wr_go && widx == OFS_IRQ_STAT[5:2]) begin
			n.irq_stat = r.irq_stat & ~hwdata[IRQ_W-1:0];
		end
		if (irq_clear) begin
			n.irq_stat = '0;
		end
		n.irq_stat = n.irq_stat | ev;
		// A set mask bit hides its status bit from the interrupt line
		n.irq      = |(n.irq_stat & ~n.irq_mask);

		////////////////////////////////////////////////////////////////////////
		// Read data, presented in the data phase
		n.hrdata = '0;
		if (rd_go) begin
			case (dtu_reg_index(haddr))
				OFS_CTRL[5:2]:     n.hrdata = {24'h000000, r.ctrl};
				OFS_INTERVAL[5:2]: n.hrdata = {16'h0000, r.interval};
				OFS_COUNT[5:2]:    n.hrdata = {16'h0000, r.count};
				OFS_DAC0[5:2]:     n.hrdata = {20'h00000, r.dac0_out};
				OFS_DAC1[5:2]:     n.hrdata = {20'h00000, r.dac1_out};
				OFS_STATUS[5:2]:   n.hrdata = {16'h0000, r.smp_cnt[11:0], r.state};
				OFS_IRQ_STAT[5:2]: n.hrdata = {30'h00000000, r.irq_stat};
				OFS_IRQ_MASK[5:2]: n.hrdata = {30'h00000000, r.irq_mask};
				default:           n.hrdata = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r             <= '0;
			r.sync.s1     <= 3'h7;
			r.sync.s2     <= 3'h7;
			r.sync.prev   <= 3'h7;
			r.ctrl        <= CTRL_RST;
			r.interval    <= INTERVAL_RST;
			r.count       <= COUNT_RST;
			r.state       <= ST_IDLE;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops; slave is zero wait state, always OKAY
	assign hrdata           = r.hrdata;
	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;
	assign adc_convert      = r.conv_pulse;
	assign dac_write_strobe = r.dac_strobe;
	assign dac0_value       = r.dac0_out;
	assign dac1_value       = r.dac1_out;
	assign host_irq         = r.irq;

endmodule // dtu_core

// >>> dv/dtu_chk.sv
// Port checker for dtu_core.
// Assumes write data arrives one edge after the address phase.
`timescale 1ns/1ps
module dtu_chk (
	input wire logic	hclk,
	input wire logic	hresetn,
	input wire logic	hsel,
	input wire logic [7:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic [31:0]	hwdata,
	input wire logic	hready,
	input wire logic	ext_convert_n,
	input wire logic	ext_trigger_in,
	input wire logic	ext_dac_load_n,
	input wire logic	irq_clear,
	input wire logic	gp_counter1_out,
	input wire logic	adc_convert,
	input wire logic	dac_write_strobe,
	input wire logic [dtu_pkg::DAC_W-1:0]	dac0_value,
	input wire logic	host_irq
);
	import dtu_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic	wa, wd, cp, tp, ts;
	logic [7:0]	wad;
	logic [CTRL_W-1:0]	cm;
	logic [3:0]	fa, lo, hi, qt;
	assign wa = hsel && hready && htrans[1] && hwrite;
	// Saturating ages of input levels; mirror of the control word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wd, tp, ts, wad, cm} <= '0;
			cp <= 1'b1;
			{fa, lo, hi, qt} <= '1;
		end else begin
			wd <= wa;
			wad <= haddr;
			cp <= ext_convert_n;
			tp <= ext_trigger_in;
			if (wd && wad == OFS_CTRL) cm <= hwdata[CTRL_W-1:0];
			ts <= !(wd && wad == OFS_CTRL) && (ts || (ext_trigger_in && !tp));
			fa <= (cp && !ext_convert_n) ? 4'h0 : fa + {3'h0, fa != 4'hf};
			lo <= ext_dac_load_n ? 4'h0 : lo + {3'h0, lo != 4'hf};
			hi <= !ext_dac_load_n ? 4'h0 : hi + {3'h0, hi != 4'hf};
			qt <= (irq_clear || wa || wd) ? 4'h0 : qt + {3'h0, qt != 4'hf};
		end
	end
	//////////////////////////////////////////////////////////////////
	sequence s_wr(logic [7:0] a);
		wa && haddr == a;
	endsequence
	property p_strobe;
		(s_wr(OFS_DAC0) or s_wr(OFS_DAC1)) |=> ##1 dac_write_strobe;
	endproperty
	property p_dac_imm;
		logic [DAC_W-1:0] v;
		s_wr(OFS_DAC0) ##0 !cm[CTRL_DEFERRED] ##1 (1, v = hwdata[DAC_W-1:0])
			|=> ##[0:1] dac0_value == v;
	endproperty
	property p_dac_def;
		logic [DAC_W-1:0] v;
		s_wr(OFS_DAC0) ##0 (cm[CTRL_DEFERRED] && lo >= 4'h4) ##1 (1, v = hwdata[DAC_W-1:0])
			|=> ##[0:1] dac0_value == v;
	endproperty
	property p_dac_hold;
		cm[CTRL_DEFERRED] && hi >= 4'h6 |=> $stable(dac0_value);
	endproperty
	property p_irq_hold;
		host_irq && qt >= 4'h3 && !irq_clear |=> host_irq;
	endproperty
	property p_gp_gate;
		adc_convert && cm[CTRL_GP_START] && !cm[CTRL_EXT_CONV] |-> $past(gp_counter1_out);
	endproperty
	// Two sync stages put the pulse at least two cycles after the fall
	property p_conv_src;
		adc_convert && cm[CTRL_EXT_CONV] |-> fa inside {[4'h2:4'h6]};
	endproperty
	property p_conv_one;
		adc_convert |=> !adc_convert;
	endproperty
	property p_trig_gate;
		cm[CTRL_HW_TRIG] && !cm[CTRL_EARLY] && !ts |-> !adc_convert;
	endproperty
	a_strobe:
		assert property (p_strobe) else $error("dac strobe missing");
	a_dac_imm:
		assert property (p_dac_imm) else $error("dac0 not updated at once");
	a_dac_def:
		assert property (p_dac_def) else $error("dac0 not updated while load low");
	a_dac_hold:
		assert property (p_dac_hold) else $error("dac0 moved while load high");
	a_irq_hold:
		assert property (p_irq_hold) else $error("irq dropped without clear");
	a_conv_src:
		assert property (p_conv_src) else $error("conversion without synced fall");
	a_conv_one:
		assert property (p_conv_one) else $error("conversion pulse too long");
	a_trig_gate:
		assert property (p_trig_gate) else $error("conversion before trigger");
	a_gp_gate:
		assert property (p_gp_gate) else $error("interval tick without counter output");
endmodule // dtu_chk

bind dtu_core dtu_chk u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .ext_convert_n(ext_convert_n),
	.ext_trigger_in(ext_trigger_in), .ext_dac_load_n(ext_dac_load_n),
	.irq_clear(irq_clear), .gp_counter1_out(gp_counter1_out),
	.adc_convert(adc_convert), .dac_write_strobe(dac_write_strobe),
	.dac0_value(dac0_value), .host_irq(host_irq)
);

// >>> dv/dtu_src.sv
// Far-side sources: conversion strobe and DAC load level.
// Assumes the bench changes half and lvl just after clock edges.
`timescale 1ns/1ps
module dtu_src (
	input wire logic	hclk,
	input wire logic	run,
	input wire logic [3:0]	half,
	input wire logic	lvl,
	output logic	ext_convert_n,
	output logic	ext_dac_load_n
);
	logic [3:0]	cnt;
	initial begin
		ext_convert_n = 1'b1;
		ext_dac_load_n = 1'b1;
		cnt = 4'h0;
	end
	// Strobe idles high between runs; half sets prompt or slow pacing
	always @(posedge hclk) begin
		cnt <= (cnt >= half) ? 4'h0 : cnt + 4'h1;
		ext_dac_load_n <= lvl;
		if (!run)
			ext_convert_n <= 1'b1;
		else if (cnt >= half)
			ext_convert_n <= !ext_convert_n;
	end
endmodule // dtu_src

// >>> dv/tb.sv
// Bench for dtu_core: AHB tasks, source partner, queued scoreboard.
// Assumes dtu_src and the bound checker are compiled first.
`timescale 1ns/1ps
module tb;
	import dtu_pkg::*;
	typedef struct {string n; logic [31:0] v;} dtu_note_s;
	logic	hclk, hresetn, hsel, hwrite, ext_trigger_in, irq_clear, run, lvl, rd_ph, snap;
	logic	nclr, sd, hreadyout, hresp, ext_convert_n, ext_dac_load_n, adc_convert;
	logic	dac_write_strobe, host_irq, mi, gp;
	logic [7:0]	haddr, nconv;
	logic [1:0]	htrans;
	logic [3:0]	half;
	logic [6:0]	mn;
	logic [31:0]	hwdata, hrdata, r;
	logic [DAC_W-1:0]	dac0_value, dac1_value, md0, md1;
	int	err_total, tests_run;
	dtu_note_s	q[$];
	dtu_note_s	e;
	wire [31:0]	obs = {host_irq, nconv[6:0], dac1_value, dac0_value};
	dtu_core dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ext_convert_n(ext_convert_n), .ext_trigger_in(ext_trigger_in),
		.ext_dac_load_n(ext_dac_load_n), .gp_counter1_out(gp), .irq_clear(irq_clear),
		.adc_convert(adc_convert), .dac_write_strobe(dac_write_strobe),
		.dac0_value(dac0_value), .dac1_value(dac1_value), .host_irq(host_irq)
	);
	dtu_src src (
		.hclk(hclk), .run(run), .half(half), .lvl(lvl),
		.ext_convert_n(ext_convert_n), .ext_dac_load_n(ext_dac_load_n)
	);
	//////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", n, x, s);
		end
	endtask
	task automatic note(input string n);
		q.push_back('{n, {mi, mn, md1, md0}});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		rd_ph <= !w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input string n);
		q.push_back('{n, v});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic look(input string n);
		note(n);
		snap <= 1'b1;
		tick(1);
		snap <= 1'b0;
		tick(1);
	endtask
	// Drives the bench signal itself; a copied-out argument would only move at return
	task automatic pulse(input logic clr);
		if (clr) irq_clear <= 1'b1;
		else ext_trigger_in <= 1'b1;
		tick(6);
		if (clr) irq_clear <= 1'b0;
		else ext_trigger_in <= 1'b0;
		tick(300);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Results: read data, snapshots, and the cycle after each DAC strobe
	always @(posedge hclk) begin
		nconv <= nclr ? 8'h00 : nconv + {7'h00, adc_convert};
		sd <= dac_write_strobe;
		if (rd_ph || snap || sd) begin
			e = q.pop_front();
			chk(e.n, rd_ph ? hrdata : obs, e.v);
		end
	end
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		tick(20000);
		err_total++;
		summarize();
	end
	initial begin
		{hresetn, hsel, hwrite, ext_trigger_in, irq_clear, rd_ph, snap, run, mi, gp} = '0;
		{haddr, htrans, hwdata, mn, md0, md1} = '0;
		{nclr, lvl} = 2'b11;
		half = 4'h3;
		r = $urandom(32'h1cdf5671);
		tick(8);
		hresetn <= 1'b1;
		nclr <= 1'b0;
		tick(1);
		rd(OFS_CTRL, 32'h0, "ctrl");
		rd(OFS_INTERVAL, {16'h0, INTERVAL_RST}, "interval");
		rd(OFS_COUNT, {16'h0, COUNT_RST}, "count");
		r = $urandom | 32'h10;
		xfer(1'b1, OFS_INTERVAL, r);
		rd(OFS_INTERVAL, {16'h0, r[15:0]}, "interval rw");
		xfer(1'b1, 8'h20, r);
		rd(8'h20, 32'h0, "unmapped");
		$display("test registers done");
		// Prompt then slow strobe; count 3 yields two extra pulses
		for (int k = 0; k < 2; k++) begin
			half <= k ? 4'h9 : 4'h3;
			nclr <= 1'b1;
			mn = 7'h00;
			xfer(1'b1, OFS_COUNT, 32'h3);
			nclr <= 1'b0;
			xfer(1'b1, OFS_CTRL, 32'h17);
			run <= 1'b1;
			tick(100);
			look("before trigger");
			pulse(1'b0);
			pulse(1'b1);
			mn = 7'h05;
			look("count stop");
			pulse(1'b0);
			look("second trigger");
			run <= 1'b0;
			xfer(1'b1, OFS_CTRL, 32'h0);
			tick(20);
		end
		$display("test trigger done");
		// Early capture drops the hardware trigger bit and forces controlled mode
		xfer(1'b1, OFS_CTRL, 32'h0f);
		rd(OFS_CTRL, 32'h1b, "early forces");
		xfer(1'b1, OFS_CTRL, 32'h0);
		// Counter 1 output gates interval ticks; reload of 16 gives a 17-cycle period
		xfer(1'b1, OFS_INTERVAL, 32'h10);
		nclr <= 1'b1;
		mn = 7'h00;
		xfer(1'b1, OFS_CTRL, 32'h81);
		nclr <= 1'b0;
		tick(100);
		look("gp gated off");
		gp <= 1'b1;
		tick(100);
		gp <= 1'b0;
		xfer(1'b1, OFS_CTRL, 32'h0);
		mn = 7'h06;
		look("gp paced");
		$display("test gp start done");
		r = $urandom;
		md0 = r[11:0];
		note("dac0 now");
		xfer(1'b1, OFS_DAC0, r);
		xfer(1'b1, OFS_CTRL, 32'h20);
		tick(4);
		r = $urandom;
		note("dac1 held");
		xfer(1'b1, OFS_DAC1, r);
		lvl <= 1'b0;
		tick(8);
		md1 = r[11:0];
		look("dac1 loaded");
		r = $urandom;
		md0 = r[11:0];
		note("dac0 while low");
		xfer(1'b1, OFS_DAC0, r);
		$display("test dac done");
		xfer(1'b1, OFS_CTRL, 32'h60);
		lvl <= 1'b1;
		tick(8);
		rd(OFS_IRQ_STAT, 32'h1, "update status");
		mi = 1'b1;
		look("irq raised");
		xfer(1'b1, OFS_IRQ_MASK, 32'h1);
		tick(4);
		mi = 1'b0;
		look("irq masked");
		xfer(1'b1, OFS_IRQ_MASK, 32'h0);
		tick(4);
		mi = 1'b1;
		look("irq held");
		pulse(1'b1);
		mi = 1'b0;
		look("irq cleared");
		rd(OFS_IRQ_STAT, 32'h0, "status cleared");
		$display("test irq done");
		summarize();
	end
endmodule // tb
